// ===== bench/pxbar_pin_model.sv
// ============================================================
// pxbar_pin_model
// ============================================================
// Purpose: board side of the port, resolves each pin wire
// Assumes: the bench drives a pin only where the crossbar lets go
// Notes:   a floating pin toggles every cycle instead of holding
`timescale 1ns/100ps
module pxbar_pin_model (
	// clock
	input  wire logic       clk,
	// crossbar side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	// board side
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_wire
);
	logic [7:0] float_val = 8'h5A; // level of an undriven pin

	// no keeper on the board, so a floating pin must not look stable
	always @(posedge clk) begin
		float_val <= ~float_val;
	end

	// ============================================================
	// wire resolution: cell driver, board driver, pull-up, float
	// ============================================================
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i]) begin
				pin_wire[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_wire[i] = ext_val[i];
			end else if (pin_pullup[i]) begin
				pin_wire[i] = 1'b1; // weak high
			end else begin
				pin_wire[i] = float_val[i];
			end
		end
	end
endmodule

// ===== bench/tb.sv
// ============================================================
// tb
// ============================================================
// Purpose: self-checking bench for the pin crossbar
// Assumes: one byte register access per cycle, board model on pins
// Notes:   expectations are hand-worked pin maps per scenario
`timescale 1ns/100ps
module tb
	import pxbar_pkg::*;
;
	logic       ref_clk   = 1'b0;  // 50 MHz
	logic       reset     = 1'b1;  // held 16 cycles
	logic [7:0] sfr_addr  = 8'h00; // register bus
	logic [7:0] sfr_wdata = 8'h00;
	logic       sfr_wr    = 1'b0;
	logic [7:0] sfr_rdata;
	logic [7:0] pin_in, pin_out, pin_oe, pin_pullup;
	logic       ser_tx = 1'b1, sda_drv = 1'b1, scl_drv = 1'b1; // peripheral drives
	logic       cmp_s = 1'b0, cmp_a = 1'b0, sys_inv = 1'b0;
	logic [2:0] mod_out = 3'h0;
	logic       ser_rx, sda_sense, scl_sense, eci_in, t0_in, t1_in;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00; // board drivers
	int         bad_count = 0;
	int         tests_run = 0;

	always #10 ref_clk = ~ref_clk;

	pxbar_top i_dut (.REF_CLK(ref_clk), .RESET(reset), .SFR_ADDR(sfr_addr),
		.SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RDATA(sfr_rdata), .PIN_IN(pin_in),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULLUP(pin_pullup),
		.SERIAL_TRANSMIT(ser_tx), .SDA_DRIVE(sda_drv), .SCL_DRIVE(scl_drv),
		.CMP_SYNC_OUT(cmp_s), .CMP_ASYNC_OUT(cmp_a), .SYSCLK_INV_OUT(sys_inv),
		.MODULE_OUTPUTS(mod_out), .SERIAL_RECEIVE(ser_rx), .SDA_SENSE(sda_sense),
		.SCL_SENSE(scl_sense), .ECI_IN(eci_in), .T0_IN(t0_in), .T1_IN(t1_in));

	pxbar_pin_model i_pins (.clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_wire(pin_in));

	// ============================================================
	// shared tasks
	// ============================================================
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// one-cycle write strobe, data held with it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge ref_clk);
		sfr_wr    <= 1'b0;
	endtask

	// read data registered one edge after the address is seen
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		sfr_addr <= a;
		repeat (2) @(posedge ref_clk);
		#1;
		check(what, sfr_rdata, exp);
	endtask

	// long enough for the two-flop pin path as well
	task automatic settle;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	// setup in the recommended order, enable last
	task automatic cfg(input logic [7:0] im, om, sk, rt, en);
		wr(ADDR_PORT, 8'hFF);
		wr(ADDR_IN_MODE, im);
		wr(ADDR_OUT_MODE, om);
		wr(ADDR_SKIP, sk);
		wr(ADDR_ROUTE, rt);
		wr(ADDR_ROUTE_EN, en);
		settle();
	endtask

	// ============================================================
	// scenarios
	// ============================================================
	task automatic t_reset;
		settle();
		check("oe after reset", pin_oe, 8'h00);
		check("pullup after reset", pin_pullup, 8'hFF);
		rd(ADDR_SKIP, 8'h00, "skip reset");
		rd(ADDR_ROUTE, 8'h00, "route reset");
		rd(ADDR_ROUTE_EN, 8'h00, "enable reset");
		rd(ADDR_IN_MODE, 8'hFF, "input mode reset");
		rd(ADDR_OUT_MODE, 8'h00, "output mode reset");
		wr(ADDR_SKIP, 8'hFF);
		rd(ADDR_SKIP, 8'h7F, "skip top bit");
		wr(ADDR_ROUTE_EN, 8'hFF);
		rd(ADDR_ROUTE_EN, 8'hC7, "enable unused bits");
		wr(ADDR_ROUTE_EN, 8'h00);
		wr(8'h55, 8'hAA);
		rd(8'h55, 8'h00, "unmapped read");
	endtask

	// serial fixed on skipped pins, bus open-drain, rest in order
	// the two comparator outputs differ so a swapped order shows
	task automatic t_priority;
		@(posedge ref_clk);
		ser_tx  <= 1'b0;
		sda_drv <= 1'b0;
		scl_drv <= 1'b1;
		cmp_a   <= 1'b1;
		cfg(8'hFF, 8'hFF, 8'h32, 8'h37, 8'h40);
		check("prio oe", pin_oe, 8'hFB);
		check("prio out", pin_out & pin_oe, 8'hE2);
		check("prio pullup", pin_pullup, 8'h04);
		check("sda sense", {7'h0, sda_sense}, 8'h00);
		check("scl sense", {7'h0, scl_sense}, 8'h01);
		check("rx sense", {7'h0, ser_rx}, 8'h01);
		@(posedge ref_clk);
		ser_tx <= 1'b1;
		@(posedge ref_clk);
		#1;
		check("tx follows", pin_out & pin_oe, 8'hF2);
	endtask

	// skips, counter outputs, input enables, analog pin, pull-up off
	// pins 0 and 2 skipped as if held by users outside the crossbar
	task automatic t_skip;
		@(posedge ref_clk);
		ext_en  <= 8'h40;
		ext_val <= 8'h00;
		sys_inv <= 1'b1;
		mod_out <= 3'b110;
		cfg(8'h7F, 8'h00, 8'h05, 8'hC8, 8'h47);
		check("skip oe", pin_oe, 8'h08);
		check("skip out", pin_out & pin_oe, 8'h00);
		check("skip pullup", pin_pullup, 8'h77);
		check("eci sense", {7'h0, eci_in}, 8'h00);
		check("t0 analog", {7'h0, t0_in}, 8'h01);
		check("t1 unrouted", {7'h0, t1_in}, 8'h01);
		rd(ADDR_PORT, 8'hB7, "port read");
		// two counter outputs: inputs move down one pin
		wr(ADDR_ROUTE, 8'h88);
		settle();
		check("two outputs oe", pin_oe, 8'h08);
		check("t0 on pin 6", {7'h0, t0_in}, 8'h00);
		check("eci on pin 5", {7'h0, eci_in}, 8'h01);
		// one counter output: timer one reaches the driven pin
		wr(ADDR_ROUTE, 8'h48);
		settle();
		check("t1 on pin 6", {7'h0, t1_in}, 8'h00);
		check("t0 on pin 5", {7'h0, t0_in}, 8'h01);
		wr(ADDR_ROUTE_EN, 8'hC7);
		settle();
		check("pullup disabled", pin_pullup, 8'h00);
		@(posedge ref_clk);
		ext_en <= 8'h00;
	endtask

	// bus takes two pins or none
	task automatic t_mgmt;
		@(posedge ref_clk);
		sda_drv <= 1'b0;
		scl_drv <= 1'b0;
		cfg(8'hFF, 8'h00, 8'h7E, 8'h04, 8'h40);
		check("bus pair oe", pin_oe, 8'h81);
		wr(ADDR_SKIP, 8'h7F);
		settle();
		check("bus single pin oe", pin_oe, 8'h00);
	endtask

	// routing off: nothing drives, whatever else is set
	task automatic t_off;
		cfg(8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00);
		wr(ADDR_PORT, 8'h00);
		settle();
		check("routing off oe", pin_oe, 8'h00);
		check("routing off out", pin_out, 8'h00);
	endtask

	// ============================================================
	// verdict and run control
	// ============================================================
	task automatic tally_and_finish;
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_priority();
		t_skip();
		t_mgmt();
		t_off();
		tally_and_finish();
	end

	// run needs under two hundred cycles; this is far beyond that
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		tally_and_finish();
	end
endmodule

// ===== inc/pxbar_pkg.sv
// ============================================================
// pxbar_pkg
// ============================================================
// Purpose: constants and types shared by the pin crossbar
// Assumes: byte-wide special-register access, 8-pin port
// Notes:   function codes follow decoder priority order
package pxbar_pkg;

	// ============================================================
	// register addresses
	// ============================================================
	localparam logic [7:0] ADDR_PORT     = 8'h80; // port latch / pin read
	localparam logic [7:0] ADDR_OUT_MODE = 8'hA4; // output mode bits
	localparam logic [7:0] ADDR_SKIP     = 8'hE1; // pin skip select
	localparam logic [7:0] ADDR_ROUTE    = 8'hE2; // peripheral route select
	localparam logic [7:0] ADDR_ROUTE_EN = 8'hE3; // route enable register
	localparam logic [7:0] ADDR_IN_MODE  = 8'hF1; // input mode bits

	// ============================================================
	// reset values
	// ============================================================
	localparam logic [7:0] RST_PORT     = 8'hFF; // latch released high
	localparam logic [7:0] RST_IN_MODE  = 8'hFF; // all digital
	localparam logic [7:0] RST_OUT_MODE = 8'h00; // all open-drain
	localparam logic [7:0] RST_ZERO     = 8'h00; // routing registers
	localparam logic [7:0] ALL_ONES     = 8'hFF; // all-pins mask

	// ============================================================
	// field positions
	// ============================================================
	localparam int SKIP_W      = 7; // skip bits 6..0
	localparam int RT_TX       = 0; // serial transmit enable
	localparam int RT_RX       = 1; // serial receive enable
	localparam int RT_MGMT     = 2; // management bus enable
	localparam int RT_SYSCLK   = 3; // inverted clock out enable
	localparam int RT_CMP      = 4; // comparator out enable
	localparam int RT_CMP_ASYN = 5; // async comparator enable
	localparam int RT_CEX_LO   = 6; // counter-array field low bit
	localparam int RT_CEX_HI   = 7; // counter-array field high bit
	localparam int RE_ECI      = 0; // counter clock input enable
	localparam int RE_T0       = 1; // timer zero input enable
	localparam int RE_T1       = 2; // timer one input enable
	localparam int RE_XBAR     = 6; // routing enable
	localparam int RE_PUD      = 7; // pull-up disable
	localparam logic [7:0] RE_MASK = 8'hC7; // implemented bits
	localparam int PIN_TX      = 4; // fixed transmit pin
	localparam int PIN_RX      = 5; // fixed receive pin
	localparam int NUM_PINS    = 8; // port width
	localparam int NUM_RES     = 11; // prioritized resources
	localparam int NUM_CEX     = 3; // counter-array outputs

	// ============================================================
	// per-pin function, priority order from SDA upward
	// ============================================================
	typedef enum logic [3:0] {
		FN_GPIO = 4'h0, FN_TX  = 4'h1, FN_RX   = 4'h2, FN_SDA  = 4'h3,
		FN_SCL  = 4'h4, FN_CMP = 4'h5, FN_CMPA = 4'h6, FN_SYS  = 4'h7,
		FN_MODULE_OUTPUT_FIRST = 4'h8, FN_CEX1 = 4'h9, FN_CEX2 = 4'hA, FN_ECI = 4'hB,
		FN_T0   = 4'hC, FN_T1  = 4'hD
	} pxbar_func_t;

endpackage

// ===== src/pxbar_decode.sv
// ============================================================
// pxbar_decode
// ============================================================
// Purpose: priority decoder mapping resources onto port pins
// Assumes: request vector in priority order, SDA first
// Notes:   purely combinational; caller registers the result
`timescale 1ns/100ps
module pxbar_decode
	import pxbar_pkg::*;
(
	// settings
	input  wire logic [SKIP_W-1:0]  skip_bits,
	input  wire logic               serial_tx_route_en,
	input  wire logic               serial_rx_route_en,
	input  wire logic [NUM_RES-1:0] res_req,
	// result
	output pxbar_func_t             pin_func [NUM_PINS]
);

	// lowest pin not yet taken, with a found flag
	function automatic logic [3:0] first_free(input logic [NUM_PINS-1:0] taken);
		logic [3:0] res;
		res = 4'h0;
		for (int p = NUM_PINS - 1; p >= 0; p--) begin
			if (!taken[p]) begin
				res = {1'b1, 3'(p)};
			end
		end
		return res;
	endfunction

	logic [NUM_PINS-1:0] taken; // pins claimed or skipped
	logic [3:0]          slot;  // found flag and pin index
	logic                pair_ok; // room for both bus lines

	// ============================================================
	// assignment walk
	// ============================================================
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			pin_func[p] = FN_GPIO; // unclaimed pins stay gpio
		end
		taken = {1'b0, skip_bits}; // skipped pins look taken
		// serial pins are fixed and beat skip and priority
		if (serial_tx_route_en) begin
			taken[PIN_TX]    = 1'b1;
			pin_func[PIN_TX] = FN_TX;
		end
		if (serial_rx_route_en) begin
			taken[PIN_RX]    = 1'b1;
			pin_func[PIN_RX] = FN_RX;
		end
		// bus lines come as a pair or not at all
		pair_ok = ($countones(~taken) >= 2);
		slot    = 4'h0;
		for (int r = 0; r < NUM_RES; r++) begin
			// lowest free pin per resource, walked in priority order
			if (res_req[r] && (r > 1 || pair_ok)) begin
				slot = first_free(taken);
				if (slot[3]) begin
					taken[slot[2:0]]    = 1'b1;
					pin_func[slot[2:0]] = pxbar_func_t'(4'(FN_SDA) + 4'(r));
				end
			end
		end
	end

endmodule

// ===== src/pxbar_top.sv
// ============================================================
// pxbar_top
// ============================================================
// Purpose: priority pin crossbar with port mode registers
// Assumes: special-register access of one byte per cycle
// Notes:   every pin-facing output is registered one cycle
//
// Functional notes
// - resources take lowest free pin by priority
// - serial transmit pin 4, receive pin 5
// - skip bit set means pin passed over
// - bus data and clock claimed together
// - unclaimed pins follow as general I/O
// - routing off: all pins plain inputs
// - input mode 1 digital, reset digital
// - analog pin: pull-up, driver, receiver off
// - output mode picks drain type; bus always open-drain
// - pull-up on open-drain unless disabled or low
// - port read returns pin levels
// - counter field routes zero to three outputs
// - route register single enable bits
// - skip bit 7 reads zero, ignores writes
// - routing enable is bit 6
// - enables for timer and counter inputs
// - analog pin reads back as one
`timescale 1ns/100ps
module pxbar_top
	import pxbar_pkg::*;
(
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RESET,
	// register access
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic [7:0] SFR_WDATA,
	input  wire logic       SFR_WR,
	output logic      [7:0] SFR_RDATA,
	// port pins
	input  wire logic [7:0] PIN_IN,
	output logic      [7:0] PIN_OUT,
	output logic      [7:0] PIN_OE,
	output logic      [7:0] PIN_PULLUP,
	// peripheral outputs to route
	input  wire logic       SERIAL_TRANSMIT,
	input  wire logic       SDA_DRIVE,
	input  wire logic       SCL_DRIVE,
	input  wire logic       CMP_SYNC_OUT,
	input  wire logic       CMP_ASYNC_OUT,
	input  wire logic       SYSCLK_INV_OUT,
	input  wire logic [2:0] MODULE_OUTPUTS,
	// peripheral inputs from pins
	output logic            SERIAL_RECEIVE,
	output logic            SDA_SENSE,
	output logic            SCL_SENSE,
	output logic            ECI_IN,
	output logic            T0_IN,
	output logic            T1_IN
);

	// ============================================================
	// state
	// ============================================================
	logic [SKIP_W-1:0] skip_bits;             // pin skip select
	logic [7:0]        peripheral_route_select; // route enables
	logic [7:0]        route_enable_register; // enable, pull-up, inputs
	logic [7:0]        input_mode_bits;       // 1 digital, 0 analog
	logic [7:0]        output_mode_bits;      // 1 push-pull
	logic [7:0]        port_latch;            // gpio output data
	logic [7:0]        pin_meta;              // first sync stage
	logic [7:0]        pin_sync;              // second sync stage
	logic [SKIP_W-1:0] next_skip_bits;
	logic [7:0]        next_route, next_route_en, next_in_mode;
	logic [7:0]        next_out_mode, next_latch, next_rdata;
	logic [7:0]        next_out, next_oe, next_pullup;
	logic [5:0]        next_pin_in;           // rx, sda, scl, eci, t0, t1
	logic              routing_enable;        // decoder active
	logic              pullup_disable;        // weak pull-ups off
	logic [NUM_RES-1:0] res_req;              // priority-ordered requests
	logic [7:0]        pin_sense;             // digital level seen
	logic [7:0]        bus_pins;              // forced open-drain pins
	logic [7:0]        claimed;               // decoder-assigned, not serial
	logic              value;                 // per-pin drive value
	pxbar_func_t       pin_func [NUM_PINS];   // decoder result

	assign routing_enable = route_enable_register[RE_XBAR];
	assign pullup_disable = route_enable_register[RE_PUD];

	// ============================================================
	// resource requests in decoder priority order
	// ============================================================
	always_comb begin
		res_req    = '0;
		res_req[0] = peripheral_route_select[RT_MGMT];
		res_req[1] = peripheral_route_select[RT_MGMT]; // both bus lines
		res_req[2] = peripheral_route_select[RT_CMP];
		res_req[3] = peripheral_route_select[RT_CMP_ASYN];
		res_req[4] = peripheral_route_select[RT_SYSCLK];
		// field value n routes the first n module outputs
		for (int c = 0; c < NUM_CEX; c++) begin
			res_req[5 + c] = (peripheral_route_select[RT_CEX_HI:RT_CEX_LO] > 2'(c));
		end
		res_req[8]  = route_enable_register[RE_ECI];
		res_req[9]  = route_enable_register[RE_T0];
		res_req[10] = route_enable_register[RE_T1];
	end

	pxbar_decode u_decode (
		.skip_bits          (skip_bits),
		.serial_tx_route_en (peripheral_route_select[RT_TX]),
		.serial_rx_route_en (peripheral_route_select[RT_RX]),
		.res_req            (res_req),
		.pin_func           (pin_func)
	);

	// ============================================================
	// register writes and read mux
	// ============================================================
	always_comb begin
		next_skip_bits = skip_bits;
		next_route     = peripheral_route_select;
		next_route_en  = route_enable_register;
		next_in_mode   = input_mode_bits;
		next_out_mode  = output_mode_bits;
		next_latch     = port_latch;
		if (SFR_WR) begin
			unique case (SFR_ADDR)
				ADDR_SKIP:     next_skip_bits = SFR_WDATA[SKIP_W-1:0]; // bit 7 dropped
				ADDR_ROUTE:    next_route     = SFR_WDATA;
				ADDR_ROUTE_EN: next_route_en  = SFR_WDATA & RE_MASK;
				ADDR_IN_MODE:  next_in_mode   = SFR_WDATA;
				ADDR_OUT_MODE: next_out_mode  = SFR_WDATA;
				ADDR_PORT:     next_latch     = SFR_WDATA;
				default:       next_latch     = port_latch; // unmapped write ignored
			endcase
		end
		// read returns the pin, never the latch
		unique case (SFR_ADDR)
			ADDR_SKIP:     next_rdata = {1'b0, skip_bits};
			ADDR_ROUTE:    next_rdata = peripheral_route_select;
			ADDR_ROUTE_EN: next_rdata = route_enable_register;
			ADDR_IN_MODE:  next_rdata = input_mode_bits;
			ADDR_OUT_MODE: next_rdata = output_mode_bits;
			ADDR_PORT:     next_rdata = pin_sense;
			default:       next_rdata = RST_ZERO; // unmapped reads zero
		endcase
	end

	// ============================================================
	// pin drive, pull-ups and peripheral inputs
	// ============================================================
	always_comb begin
		// analog pins read one and feed peripherals nothing
		pin_sense   = pin_sync | ~input_mode_bits;
		next_out    = '0;
		next_oe     = '0;
		next_pullup = '0;
		next_pin_in = 6'b11_1111; // unrouted inputs idle high
		bus_pins    = '0;
		claimed     = '0;
		value       = 1'b1;
		for (int p = 0; p < NUM_PINS; p++) begin
			bus_pins[p] = routing_enable && (pin_func[p] == FN_SDA || pin_func[p] == FN_SCL);
			claimed[p]  = pin_func[p] > FN_RX;
			unique case (pin_func[p])
				FN_TX:   value = SERIAL_TRANSMIT;
				FN_SDA:  value = SDA_DRIVE;
				FN_SCL:  value = SCL_DRIVE;
				FN_CMP:  value = CMP_SYNC_OUT;
				FN_CMPA: value = CMP_ASYNC_OUT;
				FN_SYS:  value = SYSCLK_INV_OUT;
				FN_MODULE_OUTPUT_FIRST: value = MODULE_OUTPUTS[0];
				FN_CEX1: value = MODULE_OUTPUTS[1];
				FN_CEX2: value = MODULE_OUTPUTS[2];
				default: value = port_latch[p]; // gpio and input functions
			endcase
			if (!routing_enable) begin
				value = 1'b1; // drivers off until enabled
			end
			if (!input_mode_bits[p]) begin
				// analog: all digital circuitry off
				next_oe[p] = 1'b0;
			end else if (output_mode_bits[p] && !bus_pins[p] && routing_enable) begin
				next_out[p] = value; // push-pull
				next_oe[p]  = 1'b1;
			end else begin
				// open-drain: only a low is driven
				next_oe[p]     = !value;
				next_pullup[p] = !pullup_disable && value;
			end
			if (routing_enable) begin
				unique case (pin_func[p])
					FN_RX:   next_pin_in[5] = pin_sense[p];
					FN_SDA:  next_pin_in[4] = pin_sense[p];
					FN_SCL:  next_pin_in[3] = pin_sense[p];
					FN_ECI:  next_pin_in[2] = pin_sense[p];
					FN_T0:   next_pin_in[1] = pin_sense[p];
					FN_T1:   next_pin_in[0] = pin_sense[p];
					default: next_pin_in[0] = next_pin_in[0];
				endcase
			end
		end
	end

	// ============================================================
	// pin synchroniser, two stages
	// ============================================================
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			pin_meta <= ALL_ONES;
			pin_sync <= ALL_ONES;
		end else begin
			pin_meta <= PIN_IN;
			pin_sync <= pin_meta;
		end
	end

	// ============================================================
	// register stage for all state and outputs but the pin synchroniser
	// ============================================================
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			skip_bits               <= '0;
			peripheral_route_select <= RST_ZERO;
			route_enable_register   <= RST_ZERO;
			input_mode_bits         <= RST_IN_MODE;
			output_mode_bits        <= RST_OUT_MODE;
			port_latch              <= RST_PORT;
			SFR_RDATA               <= RST_ZERO;
			PIN_OUT                 <= RST_ZERO;
			PIN_OE                  <= RST_ZERO;
			PIN_PULLUP              <= RST_ZERO;
			{SERIAL_RECEIVE, SDA_SENSE, SCL_SENSE, ECI_IN, T0_IN, T1_IN} <= 6'b11_1111;
		end else begin
			skip_bits               <= next_skip_bits;
			peripheral_route_select <= next_route;
			route_enable_register   <= next_route_en;
			input_mode_bits         <= next_in_mode;
			output_mode_bits        <= next_out_mode;
			port_latch              <= next_latch;
			SFR_RDATA               <= next_rdata;
			PIN_OUT                 <= next_out;
			PIN_OE                  <= next_oe;
			PIN_PULLUP              <= next_pullup;
			{SERIAL_RECEIVE, SDA_SENSE, SCL_SENSE, ECI_IN, T0_IN, T1_IN} <= next_pin_in;
		end
	end

	// ============================================================
	// assertions
	// ============================================================
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	// any driver at all while routing is off breaks the plain-input promise
	property p_off_inputs;
		!routing_enable |=> (PIN_OE == RST_ZERO) && (PIN_OUT == RST_ZERO);
	endproperty
	a_off_inputs: assert property (p_off_inputs) else $error("driver on with routing off");

	property p_tx_fixed;
		routing_enable && peripheral_route_select[RT_TX] && input_mode_bits[PIN_TX]
			&& output_mode_bits[PIN_TX]
			|=> PIN_OE[PIN_TX] && PIN_OUT[PIN_TX] == $past(SERIAL_TRANSMIT);
	endproperty
	a_tx_fixed: assert property (p_tx_fixed) else $error("transmit not on fixed pin");

	property p_analog_off;
		1'b1 |=> ((PIN_OE | PIN_PULLUP) & ~$past(input_mode_bits)) == RST_ZERO;
	endproperty
	a_analog_off: assert property (p_analog_off) else $error("analog pin has digital drive");

	property p_skip_top;
		SFR_ADDR == ADDR_SKIP |=> !SFR_RDATA[7];
	endproperty
	a_skip_top: assert property (p_skip_top) else $error("skip bit 7 reads one");

	property p_port_read;
		SFR_ADDR == ADDR_PORT |=> (SFR_RDATA | $past(input_mode_bits)) == ALL_ONES
			&& ((SFR_RDATA ^ $past(pin_sync)) & $past(input_mode_bits)) == RST_ZERO;
	endproperty
	a_port_read: assert property (p_port_read) else $error("port read not pin level");

	property p_bus_od;
		1'b1 |=> (PIN_OUT & $past(bus_pins)) == RST_ZERO;
	endproperty
	a_bus_od: assert property (p_bus_od) else $error("bus pin driven high");

	property p_pullup_low;
		1'b1 |-> (PIN_PULLUP & PIN_OE) == RST_ZERO
			&& !(pullup_disable && $past(pullup_disable) && |PIN_PULLUP);
	endproperty
	a_pullup_low: assert property (p_pullup_low) else $error("pull-up on while driving");

	property p_skip_free;
		1'b1 |-> (claimed & {1'b0, skip_bits}) == RST_ZERO;
	endproperty
	a_skip_free: assert property (p_skip_free) else $error("skipped pin was assigned");

	property p_bus_pair;
		1'b1 |-> $countones(bus_pins) == 0 || $countones(bus_pins) == 2;
	endproperty
	a_bus_pair: assert property (p_bus_pair) else $error("bus line assigned alone");

endmodule
